// file: logic/cec_consts.svh
/*
  Constants for the comparator edge counter: widths, reset values, restart count.
  Assumes inclusion by bare name from design files.
*/
`ifndef CEC_CONSTS_SVH
`define CEC_CONSTS_SVH

`define CEC_CNT_W 16
`define CEC_RESTART_CNT 16'h0001
`define CEC_CNT_RESET 16'h0000
`define CEC_RELOAD_RESET 16'hffff

`endif

// file: logic/cec_counter.sv
/*
  Comparator edge counter: a reloadable 16-bit timer in comparator-counting mode.
  Assumes software sets up count, reload and polarity while disabled, then enables.
*/
// Overview of operation
// - Count comparator output transitions, not clock ticks.
// - Polarity bit picks rising or falling edges.
// - No prescaler; each edge adds exactly one.
// - At reload value: pulse interrupt, restart at one.
// - Output pin toggles each reload when enabled.
// - Start count applies to first pass only.
// - Polarity sets initial output level.
`timescale 1ns/1ps
`include "cec_consts.svh"

module cec_counter
  import cec_pkg::*;
#(
  parameter int CNT_W = `CEC_CNT_W
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cmp_in,
  input wire cec_cfg_t cfg,
  input wire cec_wr_t wr,
  output logic [CNT_W-1:0] count,
  output logic [CNT_W-1:0] reload,
  output logic irq,
  output logic timer_out,
  output logic timer_out_oe,
  output logic running
);

  // ----------------------------------------------------------------
  // Edge qualification
  // ----------------------------------------------------------------
  logic edge_pulse;

  cec_edge_detect u_edge (
    .clk(clk),
    .reset(reset),
    .cmp_in(cmp_in),
    .edge_polarity_select(cfg.edge_polarity_select),
    .edge_pulse(edge_pulse)
  );

  // ----------------------------------------------------------------
  // Count, reload and output state
  // ----------------------------------------------------------------
  cec_state_t state;
  cec_state_t next_state;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] next_reload;
  logic next_irq;
  logic level;
  logic next_level;
  logic hit;

  // Byte merge used for both count and reload writes
  function automatic logic [CNT_W-1:0] merge_byte(input logic [CNT_W-1:0] cur, input logic hi_we,
                                                   input logic lo_we, input logic [7:0] d);
    logic [CNT_W-1:0] r;
    r = cur;
    if (hi_we) begin
      r[CNT_W-1:8] = d[CNT_W-9:0];
    end
    if (lo_we) begin
      r[7:0] = d;
    end
    return r;
  endfunction

  assign hit = (state == CEC_RUN) && edge_pulse && (count == reload);

  // Next-state computation
  always_comb begin
    next_state = cfg.enable ? CEC_RUN : CEC_IDLE;
    next_count = count;
    next_irq = 1'b0;
    next_level = level;
    next_reload = merge_byte(reload, wr.rld_hi_we, wr.rld_lo_we, wr.wdata);
    unique case (state)
      CEC_IDLE: begin
        next_count = merge_byte(count, wr.cnt_hi_we, wr.cnt_lo_we, wr.wdata);
        next_level = cfg.edge_polarity_select;
      end
      CEC_RUN: begin
        if (edge_pulse) begin
          if (count == reload) begin
            next_count = `CEC_RESTART_CNT;
            next_irq = 1'b1;
            next_level = ~level;
          end else begin
            next_count = count + `CEC_RESTART_CNT;
          end
        end
      end
    endcase
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= CEC_IDLE;
      count <= `CEC_CNT_RESET;
      reload <= `CEC_RELOAD_RESET;
      irq <= 1'b0;
      level <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      reload <= next_reload;
      irq <= next_irq;
      level <= next_level;
    end
  end

  // Pin drive
  assign timer_out = level;
  assign timer_out_oe = cfg.out_enable;
  assign running = (state == CEC_RUN);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_hit;
    hit;
  endsequence

  chk_reload_restart: assert property (@(posedge clk) disable iff (reset)
    s_hit |=> (count == `CEC_RESTART_CNT) && irq)
    else $error("count did not restart at reload");

  chk_single_step: assert property (@(posedge clk) disable iff (reset)
    (running && edge_pulse && !hit) |=> count == $past(count) + 16'h0001)
    else $error("count did not step by one");

  chk_hold_no_edge: assert property (@(posedge clk) disable iff (reset)
    (running && !edge_pulse && $past(running)) |=> $stable(count) || !running)
    else $error("count moved without edge");

  chk_irq_cause: assert property (@(posedge clk) disable iff (reset)
    irq |-> $past(hit))
    else $error("interrupt without reload");

  chk_out_toggle: assert property (@(posedge clk) disable iff (reset)
    s_hit |=> timer_out != $past(timer_out))
    else $error("output did not toggle");

  chk_init_level: assert property (@(posedge clk) disable iff (reset)
    (!running && !cfg.enable) ##1 !running |-> timer_out == $past(cfg.edge_polarity_select))
    else $error("initial level wrong");

  chk_start_load: assert property (@(posedge clk) disable iff (reset)
    (!running && wr.cnt_lo_we && !wr.cnt_hi_we) |=> count[7:0] == $past(wr.wdata))
    else $error("start count not loaded");

  chk_no_run_change: assert property (@(posedge clk) disable iff (reset)
    (running && cfg.enable && !edge_pulse) |=> $stable(count))
    else $error("count written while running");

  // Selected comparator edge, polarity held over the two sync stages
  sequence s_pick_edge;
    (cfg.edge_polarity_select ? $rose(cmp_in) : $fell(cmp_in)) ##1 $stable(cfg.edge_polarity_select)
      ##1 $stable(cfg.edge_polarity_select);
  endsequence

  chk_sync_delay: assert property (@(posedge clk) disable iff (reset)
    s_pick_edge |-> edge_pulse)
    else $error("edge not seen two cycles later");

endmodule // cec_counter

// file: logic/cec_edge_detect.sv
/*
  Two-stage synchroniser and selectable edge detector for the comparator output.
  Assumes comparator toggles no faster than a quarter of clk.
*/
`timescale 1ns/1ps
`include "cec_consts.svh"

module cec_edge_detect
  import cec_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cmp_in,
  input wire logic edge_polarity_select,
  output logic edge_pulse
);

  logic sync_a;
  logic sync_b;
  logic prev;
  logic next_sync_a;
  logic next_sync_b;
  logic next_prev;

  // Next values of the synchroniser and history
  always_comb begin
    next_sync_a = cmp_in;
    next_sync_b = sync_a;
    next_prev = sync_b;
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      prev <= next_prev;
    end
  end

  // Rising when select is 1, falling when 0
  assign edge_pulse = edge_polarity_select ? (sync_b & ~prev) : (~sync_b & prev);

endmodule // cec_edge_detect

// file: logic/cec_pkg.sv
/*
  Types for the comparator edge counter.
  Assumes cec_consts.svh is reachable on the include path.
*/
`include "cec_consts.svh"

package cec_pkg;

  // ----------------------------------------------------------------
  // Configuration carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic edge_polarity_select;
    logic out_enable;
  } cec_cfg_t;

  // Byte writes to count and reload
  typedef struct packed {
    logic cnt_hi_we;
    logic cnt_lo_we;
    logic rld_hi_we;
    logic rld_lo_we;
    logic [7:0] wdata;
  } cec_wr_t;

  typedef enum logic [0:0] {
    CEC_IDLE = 1'b0,
    CEC_RUN = 1'b1
  } cec_state_t;

endpackage

// file: tb/cec_cmp_model.sv
/*
  Comparator output model: toggles n times, one toggle every 4 clocks.
  Assumes the block's clk and its synchronous reset.
*/
`timescale 1ns/1ps
module cec_cmp_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [7:0] n_tgl,
  output logic cmp,
  output logic busy
);
  logic [7:0] left;
  logic [1:0] div;
  // Toggle no faster than a quarter of clk
  always @(posedge clk) begin
    if (reset) begin
      cmp <= 1'b0;
      left <= 8'h00;
      div <= 2'h0;
    end else if (start) begin
      left <= n_tgl;
      div <= 2'h0;
    end else if (left != 8'h00) begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
        cmp <= ~cmp;
        left <= left - 8'h01;
      end
    end
  end
  assign busy = (left != 8'h00);
endmodule // cec_cmp_model

// file: tb/tb.sv
/*
  Testbench for the comparator edge counter: both polarities, restart, refusal.
  Assumes the design's carriers and the comparator model.
*/
`timescale 1ns/1ps
module tb;
  import cec_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic [7:0] n_tgl = 8'h00;
  logic cmp, busy, irq, timer_out, timer_out_oe, running;
  logic [15:0] count, reload;
  cec_cfg_t cfg = '0;
  cec_wr_t wr = '0;
  int err_total = 0;
  int n_tests = 0;
  int irqs = 0;
  int cyc = 0;
  int base;
  always #2.5 clk = ~clk;
  cec_cmp_model u_cec_cmp_model (.clk(clk), .reset(reset), .start(start), .n_tgl(n_tgl), .cmp(cmp), .busy(busy));
  cec_counter u_cec_counter (.clk(clk), .reset(reset), .cmp_in(cmp), .cfg(cfg), .wr(wr), .count(count),
    .reload(reload), .irq(irq), .timer_out(timer_out), .timer_out_oe(timer_out_oe), .running(running));
  // Irq pulse tally and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irqs <= irqs + 1;
    if (cyc == 3000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Byte pair write, high then low
  task automatic wr16(input logic rld, input logic [15:0] v);
    wr <= {!rld, 1'b0, rld, 1'b0, v[15:8]};
    @(posedge clk);
    wr <= {1'b0, !rld, 1'b0, rld, v[7:0]};
    @(posedge clk);
    wr <= '0;
    repeat (2) @(posedge clk);
  endtask
  // Comparator toggles, then pipeline settle
  task automatic tgl(input logic [7:0] n);
    start <= 1'b1;
    n_tgl <= n;
    @(posedge clk);
    start <= 1'b0;
    repeat (2) @(posedge clk);
    while (busy === 1'b1) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence, once per polarity; outputs looked at on the falling edge
  initial begin
    for (int p = 0; p < 2; p++) begin
      reset <= 1'b1;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      check(count, 16'h0000);
      check(reload, 16'hffff);
      check(16'({irq, timer_out, running}), 16'h0000);
      @(posedge clk);
      cfg <= {1'b0, p[0], p[0]};
      wr16(1'b0, 16'h0005);
      wr16(1'b1, 16'h0006);
      @(negedge clk);
      check(16'(timer_out), 16'(p[0]));
      check(16'(timer_out_oe), 16'(p[0]));
      check(reload, 16'h0006);
      @(posedge clk);
      cfg.enable <= 1'b1;
      base = irqs;
      @(posedge clk);
      @(negedge clk);
      check(16'(running), 16'h0001);
      @(posedge clk);
      tgl(8'h05);
      @(negedge clk);
      check(count, 16'h0001 + 16'(p[0]));
      check(16'(irqs - base), 16'h0001);
      check(16'(timer_out), 16'(!p[0]));
      @(posedge clk);
      wr16(1'b0, 16'h0033);
      @(negedge clk);
      check(count, 16'h0001 + 16'(p[0]));
      @(posedge clk);
      tgl(8'h0c);
      @(negedge clk);
      check(count, 16'h0001 + 16'(p[0]));
      check(16'(irqs - base), 16'h0002);
      check(16'(timer_out), 16'(p[0]));
      @(posedge clk);
      cfg.enable <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      check(16'(running), 16'h0000);
      @(posedge clk);
      wr16(1'b0, 16'h0001);
      @(negedge clk);
      check(count, 16'h0001);
      @(posedge clk);
    end
    print_verdict();
  end
endmodule // tb
